// file: core/spc_pkg.sv
// Constants, register map and carrier types of the serial codec port core.
// Assumes one 40 MHz clock; the serial link pins are sampled on that clock.
package spc_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0]  SPC_CTL_OFS     = 8'h00;
  localparam logic [7:0]  SPC_STS_OFS     = 8'h04;
  localparam logic [7:0]  SPC_TXW_OFS     = 8'h08;
  localparam logic [7:0]  SPC_RXW_OFS     = 8'h0C;

  // Control register
  localparam logic [31:0] SPC_CTL_RST     = 32'h00F0_0000;
  localparam logic [31:0] SPC_CTL_WMASK   = 32'h3FFF_FFFF;
  localparam int          SPC_TXR_BIT     = 31;
  localparam int          SPC_RXR_BIT     = 30;
  localparam int          SPC_TXE_BIT     = 29;
  localparam int          SPC_RXE_BIT     = 28;
  localparam int          SPC_OEDGE_BIT   = 27;
  localparam int          SPC_SEDGE_BIT   = 26;
  localparam int          SPC_TORD_BIT    = 25;
  localparam int          SPC_RORD_BIT    = 24;
  localparam int          SPC_HALF_BIT    = 8;

  // Status register
  localparam int          SPC_TM_LSB      = 0;
  localparam int          SPC_REFILL_BIT  = 4;
  localparam int          SPC_RXFULL_BIT  = 5;
  localparam int          SPC_UNDER_BIT   = 6;
  localparam int          SPC_OVER_BIT    = 7;

  // Serial word
  localparam int          SPC_WORD_W      = 16;
  localparam logic [4:0]  SPC_WORD_BITS   = 5'h10;
  localparam logic [3:0]  SPC_LAST_BIT    = 4'hF;
  localparam logic [1:0]  SPC_QUEUE_FULL  = 2'h2;

  typedef enum logic [1:0] {
    SPC_TM_NORMAL = 2'h0,
    SPC_TM_REMOTE = 2'h1,
    SPC_TM_LOCAL  = 2'h2
  } spc_tm_t;

  typedef enum logic [1:0] {
    SPC_TX_IDLE  = 2'b00,
    SPC_TX_SHIFT = 2'b01
  } spc_tx_st_t;

  typedef enum logic [1:0] {
    SPC_RX_IDLE  = 2'b00,
    SPC_RX_HALF0 = 2'b01,
    SPC_RX_HALF1 = 2'b11
  } spc_rx_st_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } spc_bus_req_t;

  typedef struct packed {
    logic clk;
    logic frame;
    logic data;
  } spc_ser_in_t;

  typedef struct packed {
    logic data;
    logic oe;
  } spc_ser_out_t;

endpackage

// file: core/spc_core.sv
// Serial codec port core: registers, transmit and receive shifters, tests.
// Assumes link pins synchronous to clk and a serial clock slower than clk/2.

module spc_core (
  input  wire logic           clk,
  input  wire logic           rst,
  input  spc_pkg::spc_bus_req_t bus_req,
  output logic [31:0]         bus_rdata,
  input  spc_pkg::spc_ser_in_t  ser_in,
  output spc_pkg::spc_ser_out_t ser_out
);
  import spc_pkg::*;

  function automatic logic head_bit(input logic [15:0] sh,
                                    input logic        lsb_first);
    head_bit = lsb_first ? sh[0] : sh[SPC_WORD_W-1];
  endfunction

  function automatic logic [15:0] shift_in(input logic [15:0] sh,
                                           input logic        d,
                                           input logic        lsb_first);
    shift_in = lsb_first ? {d, sh[15:1]} : {sh[14:0], d};
  endfunction

  // Byte address match of one register
  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  // Test mode field, unused code behaves as normal
  function automatic spc_tm_t tm_decode(input logic [1:0] code);
    case (code)
      2'h1:    tm_decode = SPC_TM_REMOTE;
      2'h2:    tm_decode = SPC_TM_LOCAL;
      default: tm_decode = SPC_TM_NORMAL;
    endcase
  endfunction

  // Registers
  logic [31:0]  ctl_r;
  spc_tm_t      tm_r;
  logic         under_r;
  logic         over_r;
  logic         rx_full_r;
  logic [31:0]  rdata_r;
  logic         sclk_q_r;

  spc_tx_st_t   tx_st_r;
  logic [15:0]  tx_sh_r;
  logic [4:0]   tx_cnt_r;
  logic [15:0]  tx_q_r [0:1];
  logic         tx_rd_r;
  logic [1:0]   tx_lvl_r;
  logic [15:0]  tx_last_r;
  logic [31:0]  tx_word_r;

  spc_rx_st_t   rx_st_r;
  logic [15:0]  rx_sh_r;
  logic [3:0]   rx_cnt_r;
  logic [15:0]  rx_h0_r;
  logic [31:0]  rx_word_r;

  // Bus decode
  logic wr_ctl;
  logic wr_sts;
  logic wr_txw;
  logic rd_rxw;
  logic tx_srst;
  logic rx_srst;
  assign wr_ctl  = bus_req.wr && reg_hit(bus_req.addr, SPC_CTL_OFS);
  assign wr_sts  = bus_req.wr && reg_hit(bus_req.addr, SPC_STS_OFS);
  assign wr_txw  = bus_req.wr && reg_hit(bus_req.addr, SPC_TXW_OFS);
  assign rd_rxw  = bus_req.rd && reg_hit(bus_req.addr, SPC_RXW_OFS);
  assign tx_srst = wr_ctl && bus_req.wdata[SPC_TXR_BIT];
  assign rx_srst = wr_ctl && bus_req.wdata[SPC_RXR_BIT];

  // Control fields
  logic tx_on;
  logic rx_on;
  logic oedge;
  logic sedge;
  logic tx_lsb;
  logic rx_lsb;
  logic half_lo;
  assign tx_on   = ctl_r[SPC_TXE_BIT];
  assign rx_on   = ctl_r[SPC_RXE_BIT];
  assign oedge   = ctl_r[SPC_OEDGE_BIT];
  assign sedge   = ctl_r[SPC_SEDGE_BIT];
  assign tx_lsb  = ctl_r[SPC_TORD_BIT];
  assign rx_lsb  = ctl_r[SPC_RORD_BIT];
  assign half_lo = ctl_r[SPC_HALF_BIT];

  // Test modes
  logic remote;
  logic local_lb;
  assign remote   = (tm_r == SPC_TM_REMOTE);
  assign local_lb = (tm_r == SPC_TM_LOCAL);

  // Serial clock edges
  logic sclk_rise;
  logic sclk_fall;
  logic tx_evt;
  logic pin_evt;
  assign sclk_rise = ser_in.clk && !sclk_q_r;
  assign sclk_fall = !ser_in.clk && sclk_q_r;
  assign tx_evt    = oedge ? sclk_fall : sclk_rise;
  assign pin_evt   = sedge ? sclk_rise : sclk_fall;

  // Transmit control
  logic        tx_start;
  logic        tx_shift_evt;
  logic        tx_end;
  logic        tx_reload;
  logic        tx_have;
  logic        tx_pop;
  logic        tx_under_evt;
  logic [15:0] tx_next;
  logic        tx_bit;
  assign tx_start     = (tx_st_r == SPC_TX_IDLE) && tx_evt && ser_in.frame
                        && tx_on && !remote;
  assign tx_shift_evt = (tx_st_r == SPC_TX_SHIFT) && tx_evt;
  assign tx_end       = tx_shift_evt && (tx_cnt_r == 5'h01);
  assign tx_reload    = tx_start || (tx_end && tx_on);
  assign tx_have      = (tx_lvl_r != 2'h0);
  assign tx_pop       = tx_reload && tx_have;
  assign tx_under_evt = tx_reload && !tx_have;
  assign tx_next      = tx_have ? tx_q_r[tx_rd_r] : tx_last_r;
  assign tx_bit       = head_bit(tx_sh_r, tx_lsb);

  // Serial output
  always_comb begin
    if (remote) begin
      ser_out.data = ser_in.data;
      ser_out.oe   = 1'b1;
    end else begin
      ser_out.data = tx_bit;
      ser_out.oe   = (tx_st_r == SPC_TX_SHIFT) && !local_lb;
    end
  end

  // Receive control
  logic        rx_bit_evt;
  logic        rx_din;
  logic        rx_go;
  logic        rx_take;
  logic        rx_done;
  logic [15:0] rx_word;
  logic [31:0] rx_pair;
  logic        rx_store;
  assign rx_bit_evt = local_lb ? tx_shift_evt : pin_evt;
  assign rx_din     = local_lb ? tx_bit : ser_in.data;
  assign rx_go      = (rx_st_r == SPC_RX_IDLE) && rx_on && !remote
                      && (local_lb ? tx_start
                                   : (pin_evt && ser_in.frame));
  assign rx_take    = rx_bit_evt && ((rx_st_r != SPC_RX_IDLE)
                                     || (rx_go && !local_lb));
  assign rx_done    = rx_take && (rx_cnt_r == SPC_LAST_BIT);
  assign rx_word    = shift_in(rx_sh_r, rx_din, rx_lsb);
  assign rx_pair    = half_lo ? {rx_word, rx_h0_r}
                              : {rx_h0_r, rx_word};
  assign rx_store   = rx_done && (rx_st_r == SPC_RX_HALF1);

  // Lone first half kept when receiver stops mid-frame
  logic [31:0] rx_lone;
  assign rx_lone = half_lo ? {rx_word_r[31:16], rx_word}
                           : {rx_word, rx_word_r[15:0]};

  // Read data
  logic [31:0] sts_view;
  logic [31:0] rd_mux;
  assign sts_view = {24'h0000_00, over_r, under_r, rx_full_r,
                     (tx_lvl_r == 2'h0), 2'b00, tm_r};
  assign rd_mux   = reg_hit(bus_req.addr, SPC_CTL_OFS) ? ctl_r :
                    reg_hit(bus_req.addr, SPC_STS_OFS) ? sts_view :
                    reg_hit(bus_req.addr, SPC_TXW_OFS) ? tx_word_r :
                    reg_hit(bus_req.addr, SPC_RXW_OFS) ? rx_word_r :
                    32'h0000_0000;
  assign bus_rdata = rdata_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r  <= 32'h0000_0000;
      sclk_q_r <= 1'b0;
    end else begin
      rdata_r  <= bus_req.rd ? rd_mux : 32'h0000_0000;
      sclk_q_r <= ser_in.clk;
    end
  end

  // Control and test mode registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_r <= SPC_CTL_RST;
      tm_r  <= SPC_TM_NORMAL;
    end else begin
      if (wr_ctl) begin
        ctl_r <= bus_req.wdata & SPC_CTL_WMASK;
      end
      if (wr_sts) begin
        tm_r <= tm_decode(bus_req.wdata[SPC_TM_LSB +: 2]);
      end
    end
  end

  // Status flags, soft reset wins over set, set wins over bus clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      under_r   <= 1'b0;
      over_r    <= 1'b0;
      rx_full_r <= 1'b0;
    end else begin
      if (tx_srst) begin
        under_r <= 1'b0;
      end else if (tx_under_evt) begin
        under_r <= 1'b1;
      end else if (wr_sts && bus_req.wdata[SPC_UNDER_BIT]) begin
        under_r <= 1'b0;
      end
      if (rx_srst) begin
        over_r <= 1'b0;
      end else if (rx_store && rx_on && rx_full_r) begin
        over_r <= 1'b1;
      end else if (wr_sts && bus_req.wdata[SPC_OVER_BIT]) begin
        over_r <= 1'b0;
      end
      if (rx_srst) begin
        rx_full_r <= 1'b0;
      end else if (rx_store && rx_on) begin
        rx_full_r <= 1'b1;
      end else if (rd_rxw) begin
        rx_full_r <= 1'b0;
      end
    end
  end

  // Transmit word register and two-entry queue
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_word_r <= 32'h0000_0000;
      tx_q_r[0] <= 16'h0000;
      tx_q_r[1] <= 16'h0000;
      tx_rd_r   <= 1'b0;
      tx_lvl_r  <= 2'h0;
    end else begin
      if (wr_txw) begin
        tx_word_r <= bus_req.wdata;
        tx_q_r[0] <= half_lo ? bus_req.wdata[15:0]
                             : bus_req.wdata[31:16];
        tx_q_r[1] <= half_lo ? bus_req.wdata[31:16]
                             : bus_req.wdata[15:0];
        tx_rd_r   <= 1'b0;
        tx_lvl_r  <= SPC_QUEUE_FULL;
      end else if (tx_srst) begin
        tx_rd_r  <= 1'b0;
        tx_lvl_r <= 2'h0;
      end else if (tx_pop) begin
        tx_rd_r  <= !tx_rd_r;
        tx_lvl_r <= tx_lvl_r - 2'h1;
      end
    end
  end

  // Transmit shifter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_st_r   <= SPC_TX_IDLE;
      tx_sh_r   <= 16'h0000;
      tx_cnt_r  <= 5'h00;
      tx_last_r <= 16'h0000;
    end else if (tx_srst) begin
      tx_st_r  <= SPC_TX_IDLE;
      tx_sh_r  <= 16'h0000;
      tx_cnt_r <= 5'h00;
    end else begin
      case (tx_st_r)
        SPC_TX_IDLE: begin
          if (tx_start) begin
            tx_st_r   <= SPC_TX_SHIFT;
            tx_sh_r   <= tx_next;
            tx_last_r <= tx_next;
            tx_cnt_r  <= SPC_WORD_BITS;
          end
        end
        SPC_TX_SHIFT: begin
          if (tx_reload) begin
            tx_sh_r   <= tx_next;
            tx_last_r <= tx_next;
            tx_cnt_r  <= SPC_WORD_BITS;
          end else if (tx_end) begin
            tx_st_r  <= SPC_TX_IDLE;
            tx_cnt_r <= 5'h00;
          end else if (tx_shift_evt) begin
            tx_sh_r  <= tx_lsb ? {1'b0, tx_sh_r[15:1]}
                               : {tx_sh_r[14:0], 1'b0};
            tx_cnt_r <= tx_cnt_r - 5'h01;
          end
        end
        default: begin
          tx_st_r <= SPC_TX_IDLE;
        end
      endcase
    end
  end

  // Receive shifter and word assembly
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_st_r   <= SPC_RX_IDLE;
      rx_sh_r   <= 16'h0000;
      rx_cnt_r  <= 4'h0;
      rx_h0_r   <= 16'h0000;
      rx_word_r <= 32'h0000_0000;
    end else if (rx_srst) begin
      rx_st_r  <= SPC_RX_IDLE;
      rx_sh_r  <= 16'h0000;
      rx_cnt_r <= 4'h0;
    end else begin
      if (rx_take) begin
        rx_sh_r  <= rx_word;
        rx_cnt_r <= rx_cnt_r + 4'h1;
      end
      case (rx_st_r)
        SPC_RX_IDLE: begin
          if (rx_go) begin
            rx_st_r <= SPC_RX_HALF0;
          end
        end
        SPC_RX_HALF0: begin
          if (rx_done) begin
            rx_h0_r <= rx_word;
            rx_st_r <= rx_on ? SPC_RX_HALF1 : SPC_RX_IDLE;
            if (!rx_on) begin
              rx_word_r <= rx_lone;
            end
          end
        end
        SPC_RX_HALF1: begin
          if (rx_done) begin
            if (!(rx_on && rx_full_r)) begin
              rx_word_r <= rx_pair;
            end
            rx_st_r <= rx_on ? SPC_RX_HALF0 : SPC_RX_IDLE;
          end
        end
        default: begin
          rx_st_r <= SPC_RX_IDLE;
        end
      endcase
    end
  end

endmodule

// file: tb/spc_core_chk.sv
// Checker for the serial codec port core, bound to spc_core.
// Assumes control, mode and tx word are shadowed from bus writes.
module spc_core_chk (
  input wire logic            clk,
  input wire logic            rst,
  input spc_pkg::spc_bus_req_t bus_req,
  input wire logic [31:0]     bus_rdata,
  input spc_pkg::spc_ser_in_t  ser_in,
  input spc_pkg::spc_ser_out_t ser_out
);
  import spc_pkg::*;
  logic [31:0] ctl_r;
  logic [31:0] txw_r;
  logic [1:0]  tm_r;
  wire wr_ctl = bus_req.wr && bus_req.addr == SPC_CTL_OFS;
  wire wr_sts = bus_req.wr && bus_req.addr == SPC_STS_OFS;
  wire wr_txw = bus_req.wr && bus_req.addr == SPC_TXW_OFS;
  wire rem = tm_r == 2'h1;
  wire loc = tm_r == 2'h2;
  wire norm = !rem && !loc;
  wire [15:0] h0 = ctl_r[SPC_HALF_BIT] ? txw_r[15:0] : txw_r[31:16];
  wire b0 = ctl_r[SPC_TORD_BIT] ? h0[0] : h0[15];
  wire go = ser_in.frame && !ser_out.oe && ctl_r[SPC_TXE_BIT] && norm
            && !ctl_r[SPC_OEDGE_BIT];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_r <= SPC_CTL_RST;
      txw_r <= '0;
      tm_r <= '0;
    end else begin
      if (wr_ctl) ctl_r <= bus_req.wdata & SPC_CTL_WMASK;
      if (wr_txw) txw_r <= bus_req.wdata;
      if (wr_sts) tm_r <= bus_req.wdata[1:0];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_ctl_readback: assert property (
    bus_req.rd && bus_req.addr == SPC_CTL_OFS |=> bus_rdata == $past(ctl_r))
    else $error("control read mismatch");
  a_remote_echo: assert property (
    rem |-> ser_out.data == ser_in.data)
    else $error("remote echo broken");
  a_remote_drive: assert property (
    rem |-> ser_out.oe)
    else $error("remote output not driven");
  a_local_quiet: assert property (
    loc |-> !ser_out.oe)
    else $error("local output not released");
  a_tx_start: assert property (
    $rose(ser_in.clk) && go |=> ser_out.oe)
    else $error("transmit did not start");
  a_first_bit: assert property (
    $rose(ser_in.clk) && go |=> ser_out.data == $past(b0))
    else $error("first bit wrong");
  a_out_edge: assert property (
    norm && $past(norm) && ser_out.oe && $past(ser_out.oe)
    && $changed(ser_out.data) |-> $past(ser_in.clk) != ctl_r[SPC_OEDGE_BIT]
    && $past(ser_in.clk, 2) == ctl_r[SPC_OEDGE_BIT])
    else $error("output changed off edge");
  a_txreset_abort: assert property (
    wr_ctl && bus_req.wdata[SPC_TXR_BIT] && !rem |=> !ser_out.oe)
    else $error("soft reset did not stop output");

  c_tx: cover property ($rose(ser_out.oe));
  c_rem: cover property (rem && $changed(ser_out.data));
  c_rx: cover property (bus_req.rd && bus_req.addr == SPC_RXW_OFS);
endmodule

bind spc_core spc_core_chk u_spc_core_chk (.clk(clk), .rst(rst),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .ser_in(ser_in),
  .ser_out(ser_out));

// file: tb/spc_codec_model.sv
// Codec partner: drives serial clock, frame sync and input data.
// Data and frame stand across both serial edges; clock idles low.
module spc_codec_model (
  input wire logic             clk,
  output spc_pkg::spc_ser_in_t  ser_in,
  input spc_pkg::spc_ser_out_t  ser_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ser_in = '0;

  // One frame of 34 serial clocks, frame high on the first
  task automatic xfer(input logic [33:0] d, output logic [33:0] q);
    for (int k = 0; k < 34; k++) begin
      ser_in.data <= d[k];
      ser_in.frame <= k == 0;
      repeat (2) @(posedge clk);
      ser_in.clk <= 1'b1;
      repeat (4) @(posedge clk);
      ser_in.clk <= 1'b0;
      repeat (2) @(posedge clk);
      q[k] = ser_out.data;
    end
    ser_in.frame <= 1'b0;
    ser_in.data <= ~d[33];
  endtask
endmodule

// file: tb/spc_core_tb_top.sv
// Testbench for the serial codec port core with a codec partner model.
// Assumes a 40 MHz clock and the bus timing of the register port.
module spc_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import spc_pkg::*;
  logic         clk = 1'b0;
  logic         rst;
  spc_bus_req_t bus_req;
  logic [31:0]  bus_rdata;
  spc_ser_in_t  ser_in;
  spc_ser_out_t ser_out;
  int           fails = 0;
  int           check_count = 0;
  int           seed = 60040;
  int           cyc = 0;
  logic [31:0]  r;

  spc_core u_spc_core (.clk(clk), .rst(rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .ser_in(ser_in), .ser_out(ser_out));
  spc_codec_model u_spc_codec_model (.clk(clk), .ser_in(ser_in),
    .ser_out(ser_out));

  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge clk);
    bus_req.wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 d = bus_rdata;
    @(posedge clk);
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Word bit that travels as the k-th serial bit
  function automatic int ix(int k, logic h, logic l);
    return ((k < 16) != h ? 16 : 0) + (l ? k % 16 : 15 - k % 16);
  endfunction

  function automatic logic [31:0] txs(logic [31:0] w, logic h, logic l);
    for (int k = 0; k < 32; k++)
      txs[ix(k, h, l)] = 1'b0;
    for (int k = 0; k < 32; k++)
      txs[k] = w[ix(k, h, l)];
  endfunction

  function automatic logic [31:0] rxw(logic [31:0] s, logic h, logic l);
    for (int k = 0; k < 32; k++)
      rxw[ix(k, h, l)] = s[k];
  endfunction

  task automatic run(input int i);
    logic        h, to, ro;
    logic [1:0]  m;
    logic [1:0]  e;
    logic [31:0] w, din, c;
    logic [33:0] got;
    h = i[0];
    to = i[1];
    ro = i[2];
    m = i == 8 ? 2'h2 : i == 9 ? 2'h1 : 2'h0;
    w = $random(seed);
    din = $random(seed);
    e = 2'($random(seed));
    c = SPC_CTL_RST | {4'h3, e, to, ro, 15'h0, h, 8'h00};
    wr(SPC_CTL_OFS, c | 32'hC000_0000);
    wr(SPC_STS_OFS, {30'h0, m});
    rd(SPC_CTL_OFS, r);
    cmp(r, c);
    if (m != 2'h1)
      wr(SPC_TXW_OFS, w);
    u_spc_codec_model.xfer({~din[31:30], din}, got);
    rd(SPC_RXW_OFS, r);
    if (m == 2'h0) begin
      cmp(got[31:0], txs(w, h, to));
      cmp(r, rxw(din, h, ro));
    end else if (m == 2'h2) begin
      cmp(r, rxw(txs(w, h, to), h, ro));
    end else begin
      cmp(got[31:0], din);
      rd(SPC_STS_OFS, r);
      cmp(r, 32'h0000_0011);
    end
    $display("test %0d done", i);
  endtask

  task automatic stop_test;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    bus_req = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(SPC_CTL_OFS, r);
    cmp(r, SPC_CTL_RST);
    rd(8'h10, r);
    cmp(r, 32'h0000_0000);
    for (int i = 0; i < 10; i++)
      run(i);
    stop_test();
  end
endmodule
